/* File: rtl/lpsc_core.sv */
// Light and proximity sensor core: sequencer, converters, thresholds, LED and bus
`timescale 1ns/1ps
// Functional notes
// - Wideband and infrared converters integrate together, 16-bit saturating results.
// - Finished conversion copies results into readable data registers.
// - Host reaches the device as target on a two-wire serial bus.
// - Interrupt stays asserted as a level until host clears it.
// - Result above upper or below lower threshold raises interrupt condition.
// - Interrupt only after programmed count of consecutive exceedances.
// - Ambient and proximity paths own thresholds and persistence, evaluated apart.
// - LED sink current selectable as 15, 30, 60 or 120 mA.
// - Power divide bit cuts LED drive by a factor of eight.
// - One to 255 LED pulses per proximity measurement.
// - Each proximity LED pulse has a 16 us period.
// - Interrupt output open-drain, active low, released when nothing pending.
// - LED sink open-drain, pulls current only during proximity pulses.
// - Ambient and proximity interrupts each have their own enable.
// - Sleep-after-interrupt option sends device to sleep once interrupt raised.
// - Wait between cycles programmable from 2.7 ms to above 8 s.
// - Proximity saturation bit set when front end saturates.
// - Programmable offset subtracted from proximity results against crosstalk.
// - Ambient gain and integration time programmable, with reduced-gain setting.
// - Ambient integration of 1 to 256 steps of 2.73 ms.
module lpsc_core #(
	parameter int         STEP_CYCLES = lpsc_pkg::STEP_CYC,
	parameter int         PULSE_CYCLES = lpsc_pkg::PULSE_CYC,
	parameter logic [6:0] DEV_ADDR = 7'h2A
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset,
	// Serial bus pins
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	// Interrupt pin, open drain
	output logic             int_n_out,
	output logic             int_n_oe,
	// LED sink pin, open drain
	output logic             led_sink_out,
	output logic             led_sink_oe,
	output logic [9:0]       led_drive_eighth_ma,
	// Converter front end, same clock
	input  wire logic        wideband_channel_pulse,
	input  wire logic        infrared_channel_pulse,
	input  wire logic        prox_pulse,
	input  wire logic        prox_afe_sat,
	// Sequencing control
	input  wire logic        power_on,
	input  wire logic        prox_en,
	input  wire logic        wait_en,
	input  wire logic        ambient_light_sensing_en,
	input  wire logic        sleep_after_int,
	input  wire logic [7:0]  wait_steps_m1,
	input  wire logic        wait_long,
	// Ambient settings
	input  wire logic [7:0]  als_steps_m1,
	input  wire logic [1:0]  als_gain,
	input  wire logic        als_gain_reduced,
	input  wire logic [15:0] als_lo,
	input  wire logic [15:0] als_hi,
	input  wire logic [3:0]  als_pers,
	input  wire logic        als_int_en,
	// Proximity settings
	input  wire logic [7:0]  prox_pulses,
	input  wire logic [7:0]  prox_offset,
	input  wire logic [1:0]  led_current_sel,
	input  wire logic        led_power_divide,
	input  wire logic [15:0] prox_lo,
	input  wire logic [15:0] prox_hi,
	input  wire logic [3:0]  prox_pers,
	input  wire logic        prox_int_en,
	// Status
	output logic [15:0]      wideband_data,
	output logic [15:0]      infrared_data,
	output logic [15:0]      prox_data,
	output logic             prox_sat,
	output logic             data_valid,
	output logic             als_int,
	output logic             prox_int,
	output logic [1:0]       seq_state
);
	localparam int W = lpsc_pkg::DATA_W;
	localparam logic [19:0] STEP_LAST  = 20'(STEP_CYCLES - 1);
	localparam logic [19:0] PULSE_LAST = 20'(PULSE_CYCLES - 1);
	localparam logic [19:0] PULSE_HALF = 20'(PULSE_CYCLES / 2);
	localparam logic [11:0] LONG_MUL   = 12'(lpsc_pkg::WAIT_LONG_MUL);

	// Elaboration checks on timing parameters
	if (STEP_CYCLES < 2 || STEP_CYCLES > 1048575) begin : g_bad_step
		$error("STEP_CYCLES out of range");
	end
	if (PULSE_CYCLES < 2 || PULSE_CYCLES > STEP_CYCLES) begin : g_bad_pulse
		$error("PULSE_CYCLES out of range");
	end

	typedef struct packed {
		lpsc_pkg::lpsc_state_e st;
		logic [19:0]           cyc;
		logic [11:0]           steps;
		logic [7:0]            pls;
		logic [W-1:0]          wb_acc;
		logic [W-1:0]          ir_acc;
		logic [W-1:0]          px_acc;
		logic                  sat_acc;
		logic [W-1:0]          wb_q;
		logic [W-1:0]          ir_q;
		logic [W-1:0]          px_q;
		logic                  sat_q;
		logic                  valid;
		logic [3:0]            als_cnt;
		logic [3:0]            px_cnt;
		logic                  als_int;
		logic                  px_int;
		logic                  led_on;
		logic [9:0]            drive;
	} lpsc_core_s;

	lpsc_core_s q, s;

	logic        wr_stb;
	logic [7:0]  wr_index;
	logic [7:0]  wr_data;
	logic [7:0]  rd_index;
	logic [7:0]  rd_data;

	// Host bus target
	lpsc_i2c_target #(
		.DEV_ADDR (DEV_ADDR)
	) u_bus (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.scl_in   (scl_in),
		.sda_in   (sda_in),
		.sda_out  (sda_out),
		.sda_oe   (sda_oe),
		.wr_stb   (wr_stb),
		.wr_index (wr_index),
		.wr_data  (wr_data),
		.rd_index (rd_index),
		.rd_data  (rd_data)
	);

	// Saturating add; top bit flags overflow
	function automatic logic [W:0] sadd(input logic [W-1:0] a, input logic [W-1:0] b);
		logic [W:0] t;
		t = {1'b0, a} + {1'b0, b};
		sadd = t[W] ? {1'b1, lpsc_pkg::DATA_MAX} : t;
	endfunction : sadd

	// Readback mux, fetched by the target when a byte starts
	always_comb begin
		unique case (rd_index)
			lpsc_pkg::IDX_WB_LO:  rd_data = q.wb_q[7:0];
			lpsc_pkg::IDX_WB_HI:  rd_data = q.wb_q[15:8];
			lpsc_pkg::IDX_IR_LO:  rd_data = q.ir_q[7:0];
			lpsc_pkg::IDX_IR_HI:  rd_data = q.ir_q[15:8];
			lpsc_pkg::IDX_PX_LO:  rd_data = q.px_q[7:0];
			lpsc_pkg::IDX_PX_HI:  rd_data = q.px_q[15:8];
			lpsc_pkg::IDX_STATUS: rd_data = {4'h0, q.sat_q, q.px_int, q.als_int, q.valid};
			default:              rd_data = 8'h00;
		endcase
	end

	logic [W-1:0]          wt;
	logic [W-1:0]          wbn;
	logic [W-1:0]          pxn;
	logic [W:0]            sum;
	logic [W:0]            pdiff;
	logic [11:0]           wbase;
	logic [11:0]           wtot;
	logic [3:0]            cn;
	logic                  done;
	logic                  als_new;
	logic                  px_new;
	logic                  out_of;
	logic                  set_als;
	logic                  set_px;
	logic                  clr_als;
	logic                  clr_px;
	logic                  pend;
	lpsc_pkg::lpsc_state_e nxt;

	// Sequencer, converters and threshold logic
	always_comb begin
		s = q;
		wbn = q.wb_q;
		pxn = q.px_q;
		sum = '0;
		pdiff = '0;
		cn = 4'h0;
		done = 1'b0;
		als_new = 1'b0;
		px_new = 1'b0;
		out_of = 1'b0;
		set_als = 1'b0;
		set_px = 1'b0;
		nxt = lpsc_pkg::ST_SLEEP;
		wt = als_gain_reduced ? 16'h0001 : (16'h0001 << als_gain);
		wbase = {4'h0, wait_steps_m1} + 12'h001;
		wtot = wait_long ? 12'(wbase * LONG_MUL) : wbase;
		clr_als = wr_stb && wr_index == lpsc_pkg::IDX_CLEAR && wr_data[lpsc_pkg::CLR_ALS_BIT];
		clr_px = wr_stb && wr_index == lpsc_pkg::IDX_CLEAR && wr_data[lpsc_pkg::CLR_PX_BIT];
		pend = q.als_int | q.px_int;
		unique case (q.st)
			lpsc_pkg::ST_SLEEP: begin
				s.led_on = 1'b0;
				done = power_on && !(sleep_after_int && pend);
			end
			lpsc_pkg::ST_PROX: begin
				s.cyc = q.cyc + 20'h0_0001;
				s.led_on = q.cyc < PULSE_HALF;
				if (q.led_on && prox_pulse) begin
					sum = sadd(q.px_acc, 16'h0001);
					s.px_acc = sum[W-1:0];
					s.sat_acc = q.sat_acc | sum[W];
				end
				if (prox_afe_sat) s.sat_acc = 1'b1;
				if (q.cyc == PULSE_LAST) begin
					s.cyc = 20'h0_0000;
					s.pls = q.pls + 8'h01;
					done = s.pls >= prox_pulses;
				end
				if (done) begin
					// Offset removal clamps at zero rather than wrapping
					pdiff = {1'b0, s.px_acc} - {9'h000, prox_offset};
					pxn = pdiff[W] ? 16'h0000 : pdiff[W-1:0];
					s.px_q = pxn;
					s.sat_q = s.sat_acc;
					px_new = 1'b1;
				end
			end
			lpsc_pkg::ST_WAIT: begin
				s.cyc = q.cyc + 20'h0_0001;
				if (q.cyc == STEP_LAST) begin
					s.cyc = 20'h0_0000;
					s.steps = q.steps + 12'h001;
					done = s.steps >= wtot;
				end
			end
			lpsc_pkg::ST_ALS: begin
				s.cyc = q.cyc + 20'h0_0001;
				// Both channels integrate over the same window
				if (wideband_channel_pulse) begin
					sum = sadd(q.wb_acc, wt);
					s.wb_acc = sum[W-1:0];
				end
				if (infrared_channel_pulse) begin
					sum = sadd(q.ir_acc, wt);
					s.ir_acc = sum[W-1:0];
				end
				if (q.cyc == STEP_LAST) begin
					s.cyc = 20'h0_0000;
					s.steps = q.steps + 12'h001;
					done = q.steps == {4'h0, als_steps_m1};
				end
				if (done) begin
					wbn = s.wb_acc;
					s.wb_q = s.wb_acc;
					s.ir_q = s.ir_acc;
					s.valid = 1'b1;
					als_new = 1'b1;
				end
			end
		endcase

		// Ambient threshold with its own persistence
		if (als_new) begin
			out_of = wbn > als_hi || wbn < als_lo;
			cn = !out_of ? 4'h0 : (q.als_cnt == 4'hF ? 4'hF : q.als_cnt + 4'h1);
			s.als_cnt = cn;
			set_als = out_of && cn >= als_pers && als_int_en;
		end
		// Proximity threshold with its own persistence
		if (px_new) begin
			out_of = pxn > prox_hi || pxn < prox_lo;
			cn = !out_of ? 4'h0 : (q.px_cnt == 4'hF ? 4'hF : q.px_cnt + 4'h1);
			s.px_cnt = cn;
			set_px = out_of && cn >= prox_pers && prox_int_en;
		end
		// Sticky until the host clears; a new event wins over the clear
		s.als_int = (q.als_int & ~clr_als) | set_als;
		s.px_int = (q.px_int & ~clr_px) | set_px;

		// Next phase follows the fixed order, skipping disabled ones
		if (done) begin
			if (q.st == lpsc_pkg::ST_SLEEP && prox_en) begin
				nxt = lpsc_pkg::ST_PROX;
			end else if (q.st <= lpsc_pkg::ST_PROX && wait_en) begin
				nxt = lpsc_pkg::ST_WAIT;
			end else if (q.st <= lpsc_pkg::ST_WAIT && ambient_light_sensing_en) begin
				nxt = lpsc_pkg::ST_ALS;
			end
			s.st = nxt;
			s.cyc = 20'h0_0000;
			s.steps = 12'h000;
			s.pls = 8'h00;
			if (nxt == lpsc_pkg::ST_PROX) begin
				s.px_acc = 16'h0000;
				s.sat_acc = 1'b0;
			end
			if (nxt == lpsc_pkg::ST_ALS) begin
				s.wb_acc = 16'h0000;
				s.ir_acc = 16'h0000;
			end
		end
		// Power off or a raised interrupt with the option set parks in sleep
		if (!power_on || (sleep_after_int && (s.als_int | s.px_int))) begin
			s.st = lpsc_pkg::ST_SLEEP;
			s.led_on = 1'b0;
		end

		// Drive level in eighths of a mA so the divided level stays exact
		unique case (led_current_sel)
			2'b00: s.drive = lpsc_pkg::LED_MA_0;
			2'b01: s.drive = lpsc_pkg::LED_MA_1;
			2'b10: s.drive = lpsc_pkg::LED_MA_2;
			2'b11: s.drive = lpsc_pkg::LED_MA_3;
		endcase
		if (!led_power_divide) s.drive = {s.drive[6:0], 3'b000};
	end

	// State register
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			q <= '0;
			q.st <= lpsc_pkg::ST_SLEEP;
		end else begin
			q <= s;
		end
	end

	// Pins and status outputs
	assign int_n_out           = 1'b0;
	assign int_n_oe            = q.als_int | q.px_int;
	assign led_sink_out        = 1'b0;
	assign led_sink_oe         = q.led_on;
	assign led_drive_eighth_ma = q.drive;
	assign wideband_data       = q.wb_q;
	assign infrared_data       = q.ir_q;
	assign prox_data           = q.px_q;
	assign prox_sat            = q.sat_q;
	assign data_valid          = q.valid;
	assign als_int             = q.als_int;
	assign prox_int            = q.px_int;
	assign seq_state           = q.st;
endmodule : lpsc_core

/* File: rtl/lpsc_pkg.sv */
// Shared constants and types of the light and proximity sensor core
package lpsc_pkg;
	// Clock and timing figures
	localparam int CLK_MHZ       = 250;
	localparam int STEP_NS       = 2730000;
	localparam int STEP_CYC      = (STEP_NS * CLK_MHZ) / 1000;
	localparam int PULSE_US      = 16;
	localparam int PULSE_CYC     = PULSE_US * CLK_MHZ;
	localparam int WAIT_LONG_MUL = 12;
	// Result width and saturation value
	localparam int          DATA_W   = 16;
	localparam logic [15:0] DATA_MAX = 16'hFFFF;
	// Read indices on the serial bus, and the clear index for writes
	localparam logic [7:0] IDX_WB_LO  = 8'h00;
	localparam logic [7:0] IDX_WB_HI  = 8'h01;
	localparam logic [7:0] IDX_IR_LO  = 8'h02;
	localparam logic [7:0] IDX_IR_HI  = 8'h03;
	localparam logic [7:0] IDX_PX_LO  = 8'h04;
	localparam logic [7:0] IDX_PX_HI  = 8'h05;
	localparam logic [7:0] IDX_STATUS = 8'h06;
	localparam logic [7:0] IDX_CLEAR  = 8'h07;
	// Bit positions in the clear byte
	localparam int CLR_ALS_BIT = 0;
	localparam int CLR_PX_BIT  = 1;
	// LED sink levels in mA
	localparam logic [9:0] LED_MA_0 = 10'h00F;
	localparam logic [9:0] LED_MA_1 = 10'h01E;
	localparam logic [9:0] LED_MA_2 = 10'h03C;
	localparam logic [9:0] LED_MA_3 = 10'h078;
	// Measurement sequencer states, ordered as the cycle runs
	typedef enum logic [1:0] {
		ST_SLEEP = 2'b00,
		ST_PROX  = 2'b01,
		ST_WAIT  = 2'b10,
		ST_ALS   = 2'b11
	} lpsc_state_e;
	// Serial target states
	typedef enum logic [2:0] {
		I_IDLE = 3'b000,
		I_ADDR = 3'b001,
		I_ACKA = 3'b010,
		I_WR   = 3'b011,
		I_ACKW = 3'b100,
		I_RD   = 3'b101,
		I_ACKR = 3'b110
	} lpsc_i2c_e;
endpackage : lpsc_pkg

/* File: rtl/lpsc_i2c_target.sv */
// Two-wire serial bus target with byte pointer, write strobe and read fetch
`timescale 1ns/1ps
module lpsc_i2c_target #(
	parameter logic [6:0] DEV_ADDR = 7'h2A
) (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       reset,
	// Bus pins
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	// Register side
	output logic            wr_stb,
	output logic [7:0]      wr_index,
	output logic [7:0]      wr_data,
	output logic [7:0]      rd_index,
	input  wire logic [7:0] rd_data
);
	typedef struct packed {
		logic [2:0]         scl_s;
		logic [2:0]         sda_s;
		logic               scl;
		logic               sda;
		lpsc_pkg::lpsc_i2c_e st;
		logic [3:0]         bits;
		logic [7:0]         sh;
		logic               rw;
		logic               first;
		logic               nack;
		logic               oe;
		logic [7:0]         ptr;
		logic               wr_stb;
		logic [7:0]         wr_idx;
		logic [7:0]         wr_dat;
	} lpsc_i2c_s;

	lpsc_i2c_s q, s;
	logic      rise, fall, start, stop;

	// Bit engine; data changes only while the clock line is low
	always_comb begin
		s = q;
		s.wr_stb = 1'b0;
		s.scl_s = {q.scl_s[1:0], scl_in};
		s.sda_s = {q.sda_s[1:0], sda_in};
		if (q.scl_s[1] == q.scl_s[2]) s.scl = q.scl_s[2];
		if (q.sda_s[1] == q.sda_s[2]) s.sda = q.sda_s[2];
		rise  = s.scl & ~q.scl;
		fall  = ~s.scl & q.scl;
		start = q.scl & s.scl & q.sda & ~s.sda;
		stop  = q.scl & s.scl & ~q.sda & s.sda;
		if (start) begin
			s.st = lpsc_pkg::I_ADDR;
			s.bits = 4'h0;
			s.oe = 1'b0;
		end else if (stop) begin
			s.st = lpsc_pkg::I_IDLE;
			s.oe = 1'b0;
		end else begin
			unique case (q.st)
				lpsc_pkg::I_IDLE: begin
				end
				lpsc_pkg::I_ADDR, lpsc_pkg::I_WR: begin
					if (rise) begin
						s.sh = {q.sh[6:0], s.sda};
						s.bits = q.bits + 4'h1;
					end else if (fall && q.bits == 4'h8) begin
						s.bits = 4'h0;
						s.oe = 1'b1; // Acknowledge low
						if (q.st == lpsc_pkg::I_ADDR) begin
							s.rw = q.sh[0];
							s.st = lpsc_pkg::I_ACKA;
							if (q.sh[7:1] != DEV_ADDR) begin
								s.oe = 1'b0;
								s.st = lpsc_pkg::I_IDLE;
							end
						end else begin
							s.st = lpsc_pkg::I_ACKW;
							if (q.first) begin
								s.ptr = q.sh; // First byte sets the pointer
								s.first = 1'b0;
							end else begin
								s.wr_stb = 1'b1;
								s.wr_idx = q.ptr;
								s.wr_dat = q.sh;
								s.ptr = q.ptr + 8'h01;
							end
						end
					end
				end
				lpsc_pkg::I_ACKA, lpsc_pkg::I_ACKR: begin
					if (rise && q.st == lpsc_pkg::I_ACKR) s.nack = s.sda;
					if (fall) begin
						if (q.rw && !(q.st == lpsc_pkg::I_ACKR && q.nack)) begin
							s.st = lpsc_pkg::I_RD;
							s.sh = {rd_data[6:0], 1'b0};
							s.oe = ~rd_data[7];
							s.bits = 4'h1;
							s.ptr = q.ptr + 8'h01;
						end else if (q.rw) begin
							s.oe = 1'b0; // Controller ended the read
							s.st = lpsc_pkg::I_IDLE;
						end else begin
							s.oe = 1'b0;
							s.st = lpsc_pkg::I_WR;
							s.first = 1'b1;
						end
					end
				end
				lpsc_pkg::I_ACKW: begin
					if (fall) begin
						s.oe = 1'b0;
						s.st = lpsc_pkg::I_WR;
					end
				end
				lpsc_pkg::I_RD: begin
					if (fall) begin
						if (q.bits == 4'h8) begin
							s.oe = 1'b0;
							s.bits = 4'h0;
							s.st = lpsc_pkg::I_ACKR;
						end else begin
							s.oe = ~q.sh[7];
							s.sh = {q.sh[6:0], 1'b0};
							s.bits = q.bits + 4'h1;
						end
					end
				end
				default: s.st = lpsc_pkg::I_IDLE;
			endcase
		end
	end

	// State register; idle lines read high
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			q <= '0;
			q.scl_s <= 3'h7;
			q.sda_s <= 3'h7;
			q.scl <= 1'b1;
			q.sda <= 1'b1;
			q.st <= lpsc_pkg::I_IDLE;
		end else begin
			q <= s;
		end
	end

	assign sda_out  = 1'b0;
	assign sda_oe   = q.oe;
	assign wr_stb   = q.wr_stb;
	assign wr_index = q.wr_idx;
	assign wr_data  = q.wr_dat;
	assign rd_index = q.ptr;
endmodule : lpsc_i2c_target

/* File: sim/lpsc_core_sva.sv */
// Pin-level checks of the light and proximity sensor core
`timescale 1ns/1ps
module lpsc_core_sva #(
	parameter int STEP_CYCLES  = 20,
	parameter int PULSE_CYCLES = 8
) (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        reset,
	// Pins
	input wire logic        sda_out,
	input wire logic        sda_oe,
	input wire logic        int_n_out,
	input wire logic        int_n_oe,
	input wire logic        led_sink_out,
	input wire logic        led_sink_oe,
	input wire logic [9:0]  led_drive_eighth_ma,
	// Controls
	input wire logic        power_on,
	input wire logic        sleep_after_int,
	input wire logic [7:0]  als_steps_m1,
	input wire logic [7:0]  prox_pulses,
	input wire logic [1:0]  led_current_sel,
	input wire logic        led_power_divide,
	// Status
	input wire logic        als_int,
	input wire logic        prox_int,
	input wire logic [1:0]  seq_state
);
	logic [1:0]  state_q;
	logic [15:0] run_q;
	logic [9:0]  drive_exp;
	int          prox_len;
	int          als_len;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	// Expected phase lengths and drive level from the settings
	assign prox_len  = ((prox_pulses == 8'h00) ? 1 : int'(prox_pulses)) * PULSE_CYCLES;
	assign als_len   = (int'(als_steps_m1) + 1) * STEP_CYCLES;
	assign drive_exp = led_power_divide ? (10'h00F << led_current_sel) : (10'h078 << led_current_sel);
	// Length of the running phase; a cut-short phase is excluded below
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_q <= 2'h0;
			run_q   <= 16'h0000;
		end else begin
			state_q <= seq_state;
			run_q   <= (seq_state == state_q) ? run_q + 16'h0001 : 16'h0001;
		end
	end
	// A phase that ended on its own, not by power-off or sleep-after-interrupt
	sequence s_phase_end(logic [1:0] st);
		state_q == st && seq_state != st && $past(power_on)
			&& !$past(sleep_after_int && (als_int || prox_int));
	endsequence
	a_prox_length: assert property (s_phase_end(2'h1) |-> run_q == prox_len)
		else $error("proximity phase length wrong");
	a_als_length: assert property (s_phase_end(2'h3) |-> run_q == als_len)
		else $error("ambient phase length wrong");
	a_led_in_prox: assert property (led_sink_oe |-> seq_state == 2'h1)
		else $error("LED sink active outside proximity phase");
	a_led_drive: assert property (($stable(led_current_sel) && $stable(led_power_divide)) [*3]
		|-> led_drive_eighth_ma == drive_exp) else $error("LED drive level wrong");
	a_int_pin: assert property ((als_int || prox_int) [*2] |-> int_n_oe)
		else $error("interrupt pin not pulled low");
	a_pins_low: assert property (!sda_out && !int_n_out && !led_sink_out)
		else $error("open-drain pin driven high");
	a_clear_by_bus: assert property (($fell(als_int) || $fell(prox_int))
		|-> sda_oe || $past(sda_oe)) else $error("interrupt dropped without host clear");
	a_power_off: assert property (!power_on |=> seq_state == 2'h0)
		else $error("sequencer runs while powered off");
	a_sleep_hold: assert property (sleep_after_int && (als_int || prox_int)
		|=> seq_state == 2'h0) else $error("no sleep after interrupt");
endmodule : lpsc_core_sva
bind lpsc_core lpsc_core_sva #(.STEP_CYCLES(STEP_CYCLES), .PULSE_CYCLES(PULSE_CYCLES))
	u_lpsc_core_sva (.*);

/* File: sim/lpsc_host.sv */
// Two-wire bus controller model standing in for the host
`timescale 1ns/1ps
module lpsc_host (
	// Bus wires; data is only ever pulled low, the pull-up makes the high
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda
);
	// Idle bus: clock parked high, data released
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// One bit in 32 ns; data moves only while the clock is low
	task automatic bit_c(input logic low, output logic v);
		sda_low = low;
		#8 scl = 1'b1;
		#8 v = sda;
		#8 scl = 1'b0;
		#8;
	endtask : bit_c
	// Start and stop conditions: data changes with the clock high
	task automatic start_c();
		sda_low = 1'b1;
		#8 scl = 1'b0;
		#8;
	endtask : start_c
	task automatic stop_c();
		sda_low = 1'b1;
		#8 scl = 1'b1;
		#8 sda_low = 1'b0;
		#16;
	endtask : stop_c
	// Byte out, most significant bit first, acknowledge returned
	task automatic put_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) bit_c(~b[i], ack);
		bit_c(1'b0, ack);
		ack = ~ack;
	endtask : put_byte
	// Pointer then one data byte
	task automatic write_reg(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d,
		output logic ok);
		logic a0, a1, a2;
		start_c();
		put_byte({a, 1'b0}, a0);
		put_byte(idx, a1);
		put_byte(d, a2);
		stop_c();
		ok = a0 & a1 & a2;
	endtask : write_reg
	// Pointer, then one byte read back and refused with no acknowledge
	task automatic read_reg(input logic [6:0] a, input logic [7:0] idx, output logic [7:0] d,
		output logic ok);
		logic a0, a1, a2, v;
		start_c();
		put_byte({a, 1'b0}, a0);
		put_byte(idx, a1);
		stop_c();
		start_c();
		put_byte({a, 1'b1}, a2);
		for (int i = 7; i >= 0; i--) begin
			bit_c(1'b0, v);
			d[i] = v;
		end
		bit_c(1'b0, v);
		stop_c();
		ok = a0 & a1 & a2;
	endtask : read_reg
endmodule : lpsc_host

/* File: sim/tb.sv */
// Self-checking bench of the light and proximity sensor core
`timescale 1ns/1ps
module tb;
	localparam int STEP  = 20;
	localparam int PULSE = 8;
	// Pins and status
	logic        clk_sys, reset, scl_in, sda_in, sda_low, sda_out, sda_oe, int_n_out, int_n_oe;
	logic        led_sink_out, led_sink_oe, prox_sat, data_valid, als_int, prox_int;
	logic [9:0]  led_drive_eighth_ma;
	logic [15:0] wideband_data, infrared_data, prox_data;
	logic [1:0]  seq_state;
	// Inputs
	logic        wideband_channel_pulse = 0, infrared_channel_pulse = 0, prox_pulse = 0;
	logic        prox_afe_sat = 0, power_on = 0, prox_en = 1, wait_en = 0, wait_long = 0;
	logic        ambient_light_sensing_en = 1, sleep_after_int = 0, als_gain_reduced = 0;
	logic        als_int_en = 0, led_power_divide = 0, prox_int_en = 0;
	logic [7:0]  wait_steps_m1 = 0, als_steps_m1 = 0, prox_pulses = 1, prox_offset = 0;
	logic [1:0]  als_gain = 0, led_current_sel = 0;
	logic [3:0]  als_pers = 0, prox_pers = 0;
	logic [15:0] als_lo = 0, als_hi = 16'hffff, prox_lo = 0, prox_hi = 16'hffff;
	// Bench state
	logic [31:0] rng = 32'h689e_f4d7;
	int          bad_count = 0, num_checks = 0, cyc = 0, wb_left = 0, ir_left = 0, led_run = 0;
	int          led_cyc, wait_cyc, w, raw;
	logic [7:0]  rd;
	logic        ok;
	// Wired-AND data line with pull-up
	assign sda_in = ~(sda_low | sda_oe);
	lpsc_core #(.STEP_CYCLES(STEP), .PULSE_CYCLES(PULSE), .DEV_ADDR(7'h2A)) u_lpsc_core (.*);
	lpsc_host u_lpsc_host (.scl(scl_in), .sda_low, .sda(sda_in));
	// 250 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// Hang guard, well above the expected run length
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 40000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	// Front-end quanta; proximity only mid-pulse, so a one-cycle LED skew cannot matter
	always @(negedge clk_sys) begin
		wideband_channel_pulse = (seq_state === 2'h3) && (wb_left > 0);
		infrared_channel_pulse = (seq_state === 2'h3) && (ir_left > 0);
		wb_left -= int'(wideband_channel_pulse);
		ir_left -= int'(infrared_channel_pulse);
		led_run = (led_sink_oe === 1'b1) ? led_run + 1 : 0;
		prox_pulse = (led_run == 2) || (led_run == 3);
	end
	function automatic int rnd(input int m);
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return int'(rng % m);
	endfunction : rnd
	function automatic int exp_prox(input int r, input int off);
		return (r > off) ? r - off : 0;
	endfunction : exp_prox
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask : chk
	// One measurement cycle from sleep back to sleep, then power off
	task automatic pass();
		led_cyc = 0;
		wait_cyc = 0;
		power_on = 1'b1;
		@(negedge clk_sys);
		while (seq_state === 2'h0) @(negedge clk_sys);
		while (seq_state !== 2'h0) begin
			led_cyc += int'(led_sink_oe === 1'b1);
			wait_cyc += int'(seq_state === 2'h2);
			@(negedge clk_sys);
		end
		power_on = 1'b0;
		repeat (4) @(negedge clk_sys);
	endtask : pass
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : tally_and_finish
	// Main sequence
	initial begin
		reset = 1'b1;
		repeat (2) @(negedge clk_sys);
		reset = 1'b0;
		@(negedge clk_sys);
		chk({seq_state, int_n_oe, sda_oe, data_valid, led_sink_oe}, 0, "reset state");
		for (int i = 0; i < 8; i++) begin
			led_current_sel = 2'(i);
			led_power_divide = 1'(i >> 2);
			repeat (3) @(negedge clk_sys);
			chk(led_drive_eighth_ma, (i > 3 ? 15 : 120) << (i % 4), "led drive");
		end
		$display("drive levels done");
		// Random measurements; first has 255 pulses, last an offset beyond the result
		for (int i = 0; i < 4; i++) begin
			wb_left = rnd(15) + 1;
			ir_left = rnd(15) + 1;
			als_gain = 2'(rnd(4));
			als_gain_reduced = (i == 1);
			als_steps_m1 = 8'(rnd(4));
			prox_pulses = (i == 0) ? 8'hff : 8'(rnd(4) + 1);
			prox_offset = (i == 3) ? 8'hff : 8'(rnd(10));
			wait_en = 1'(rnd(2));
			wait_long = (i == 2);
			wait_steps_m1 = 8'(rnd(2));
			w = als_gain_reduced ? 1 : 1 << als_gain;
			raw = (wb_left << 8) | ir_left;
			pass();
			chk(wideband_data, (raw >> 8) * w, "wideband");
			chk(infrared_data, (raw % 256) * w, "infrared");
			chk(prox_data, exp_prox(2 * prox_pulses, prox_offset), "proximity");
			chk(led_cyc, prox_pulses * PULSE / 2, "led cycles");
			chk(wait_cyc, wait_en * (wait_steps_m1 + 1) * STEP * (wait_long ? 12 : 1), "wait");
			chk({prox_sat, data_valid}, 1, "flags");
			$display("measurement %0d done", i);
		end
		// Three consecutive exceedances; proximity also out but masked
		{als_hi, prox_hi, als_pers, als_int_en, prox_offset} = {32'h0, 4'h3, 1'b1, 8'h0};
		for (int i = 1; i <= 3; i++) begin
			wb_left = 4;
			pass();
			chk(als_int, i == 3, "persistence");
			chk(prox_int, 0, "masked");
		end
		repeat (50) @(negedge clk_sys);
		chk({als_int, int_n_oe}, 3, "held");
		u_lpsc_host.read_reg(7'h2A, 8'h06, rd, ok);
		chk({ok, rd}, 9'h103, "status");
		u_lpsc_host.read_reg(7'h2A, 8'h00, rd, ok);
		chk({ok, rd}, 256 + 4 * w, "bus data");
		u_lpsc_host.write_reg(7'h2B, 8'h07, 8'h01, ok);
		chk({ok, als_int}, 1, "wrong address");
		u_lpsc_host.write_reg(7'h2A, 8'h07, 8'h01, ok);
		@(negedge clk_sys);
		chk({ok, als_int, int_n_oe}, 4, "cleared");
		$display("interrupt path done");
		// Saturated proximity interrupt with sleep-after-interrupt
		{als_int_en, prox_int_en, sleep_after_int, prox_afe_sat} = 4'b0111;
		pass();
		chk({prox_int, prox_sat}, 3, "sat int");
		power_on = 1'b1;
		repeat (20) @(negedge clk_sys);
		chk(seq_state, 0, "sleep hold");
		power_on = 1'b0;
		u_lpsc_host.write_reg(7'h2A, 8'h07, 8'h02, ok);
		@(negedge clk_sys);
		chk({ok, prox_int}, 2, "prox clear");
		power_on = 1'b1;
		repeat (3) @(negedge clk_sys);
		chk(seq_state, 1, "wake");
		$display("sleep path done");
		tally_and_finish();
	end
endmodule : tb
